//--- logic/i2cack_consts.vh
// Constants for the acknowledge sequencer: register map, fields, reset values
`ifndef I2CACK_CONSTS_VH
`define I2CACK_CONSTS_VH
`define IA_ADDR_W 12
`define IA_OFF_CTRL2 12'h000
`define IA_OFF_BUF 12'h004
`define IA_OFF_STAT 12'h008
`define IA_OFF_BAUD 12'h00C
`define IA_BIT_ACK_SEQUENCE_ENABLE 4
`define IA_BIT_ACK_DATA_VALUE 5
`define IA_BIT_WRITE_COLLISION_FLAG 0
`define IA_BIT_BUSY 1
`define IA_BIT_SCLIN 2
`define IA_BIT_SDAIN 3
`define IA_BAUD_W 8
`define IA_BAUD_RST 8'h09
`define IA_BUF_RST 8'h00
`define IA_ZERO32 32'h00000000
`endif

//--- logic/i2cack_brg.v
// Baud rate generator: reloadable down counter with rollover pulse
`timescale 1ns/10ps
`default_nettype none
module i2cack_brg #(
  parameter WIDTH = 8
) (
  input wire clk,
  input wire rst_n,
  input wire run,
  input wire reload,
  input wire [WIDTH-1:0] period,
  output wire rollover
);
  reg [WIDTH-1:0] cnt_reg;
  reg [WIDTH-1:0] cnt_next;
  assign rollover = run && !reload && (cnt_reg == {WIDTH{1'b0}});
  always @* begin
    cnt_next = cnt_reg;
    if (!run || reload || rollover) begin
      cnt_next = period;
    end else begin
      cnt_next = cnt_reg - {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= {WIDTH{1'b0}};
    end else begin
      cnt_reg <= cnt_next;
    end
  end
endmodule // i2cack_brg
`default_nettype wire

//--- logic/i2cack_top.v
// Acknowledge sequencer of a two-wire bus master with APB registers
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "i2cack_consts.vh"
module i2cack_top #(
  parameter BAUD_W = `IA_BAUD_W
) (
  input wire REF_CLK,
  input wire RST_N,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [`IA_ADDR_W-1:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output wire PREADY,
  output wire PSLVERR,
  input wire SCL_IN,
  output wire SCL_OUT,
  output wire SCL_OE,
  input wire SDA_IN,
  output wire SDA_OUT,
  output wire SDA_OE
);
  localparam S_IDLE = 4'b0001;
  localparam S_LOW = 4'b0010;
  localparam S_WAITH = 4'b0100;
  localparam S_HIGH = 4'b1000;

  reg [3:0] state_reg;
  reg [3:0] state_next;
  reg ack_sequence_enable_reg;
  reg ack_data_value_reg;
  reg write_collision_flag_reg;
  reg [7:0] shift_transfer_buffer_reg;
  reg [BAUD_W-1:0] baud_reg;
  reg scl_low_reg;
  reg sda_low_reg;
  wire brg_roll;
  wire brg_run;
  wire brg_reload;

  function is_addr;
    input [`IA_ADDR_W-1:0] a;
    input [`IA_ADDR_W-1:0] b;
    begin
      is_addr = (a == b);
    end
  endfunction

  function ack_data_from_write;
    input [31:0] d;
    begin
      ack_data_from_write = d[`IA_BIT_ACK_DATA_VALUE];
    end
  endfunction

  wire wr_en = PSEL && PENABLE && PWRITE;
  wire busy = (state_reg != S_IDLE);
  wire start_seq = wr_en && is_addr(PADDR, `IA_OFF_CTRL2) && PWDATA[`IA_BIT_ACK_SEQUENCE_ENABLE] && !busy;
  wire buf_wr = wr_en && is_addr(PADDR, `IA_OFF_BUF);
  wire mapped = is_addr(PADDR, `IA_OFF_CTRL2) || is_addr(PADDR, `IA_OFF_BUF) ||
                is_addr(PADDR, `IA_OFF_STAT) || is_addr(PADDR, `IA_OFF_BAUD);

  // Zero wait states; unmapped accesses report an error
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped;

  // Generator runs only while a phase is being timed; reload input tied off, period reloaded while stopped
  assign brg_run = (state_reg == S_LOW) || (state_reg == S_HIGH);
  assign brg_reload = 1'b0;

  i2cack_brg #(.WIDTH(BAUD_W)) u_brg (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .run(brg_run),
    .reload(brg_reload),
    .period(baud_reg),
    .rollover(brg_roll)
  );

  always @* begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE: begin
        if (start_seq) begin
          state_next = S_LOW;
        end
      end
      S_LOW: begin
        if (brg_roll) begin
          state_next = S_WAITH;
        end
      end
      S_WAITH: begin
        // Another party may stretch the clock; no timeout by design
        if (SCL_IN) begin
          state_next = S_HIGH;
        end
      end
      S_HIGH: begin
        if (brg_roll) begin
          state_next = S_IDLE;
        end
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
  end

  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg <= S_IDLE;
      ack_sequence_enable_reg <= 1'b0;
      ack_data_value_reg <= 1'b0;
      write_collision_flag_reg <= 1'b0;
      shift_transfer_buffer_reg <= `IA_BUF_RST;
      baud_reg <= `IA_BAUD_RST;
      scl_low_reg <= 1'b0;
      sda_low_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (start_seq) begin
        ack_sequence_enable_reg <= 1'b1;
      end else if (state_reg == S_HIGH && brg_roll) begin
        ack_sequence_enable_reg <= 1'b0;
      end
      // Ack data held in the same write as enable is taken in the same cycle
      if (wr_en && is_addr(PADDR, `IA_OFF_CTRL2) && !busy) begin
        ack_data_value_reg <= PWDATA[`IA_BIT_ACK_DATA_VALUE];
      end
      if (wr_en && is_addr(PADDR, `IA_OFF_BAUD) && !busy) begin
        baud_reg <= PWDATA[BAUD_W-1:0];
      end
      if (buf_wr && busy) begin
        write_collision_flag_reg <= 1'b1;
      end else if (wr_en && is_addr(PADDR, `IA_OFF_STAT) && PWDATA[`IA_BIT_WRITE_COLLISION_FLAG]) begin
        write_collision_flag_reg <= 1'b0;
      end
      if (buf_wr && !busy) begin
        shift_transfer_buffer_reg <= PWDATA[7:0];
      end
      // SCL low in low phase and again at the end; released after first period
      if (start_seq) begin
        scl_low_reg <= 1'b1;
        sda_low_reg <= !ack_data_from_write(PWDATA);
      end else if (state_reg == S_LOW && brg_roll) begin
        scl_low_reg <= 1'b0;
      end else if (state_reg == S_HIGH && brg_roll) begin
        scl_low_reg <= 1'b1;
      end
    end
  end

  // Open drain: output value always low, enable means pulling low
  assign SCL_OUT = 1'b0;
  assign SCL_OE = scl_low_reg;
  assign SDA_OUT = 1'b0;
  assign SDA_OE = sda_low_reg && busy;

  always @* begin
    PRDATA = `IA_ZERO32;
    if (is_addr(PADDR, `IA_OFF_CTRL2)) begin
      PRDATA[`IA_BIT_ACK_SEQUENCE_ENABLE] = ack_sequence_enable_reg;
      PRDATA[`IA_BIT_ACK_DATA_VALUE] = ack_data_value_reg;
    end else if (is_addr(PADDR, `IA_OFF_BUF)) begin
      PRDATA[7:0] = shift_transfer_buffer_reg;
    end else if (is_addr(PADDR, `IA_OFF_STAT)) begin
      PRDATA[`IA_BIT_WRITE_COLLISION_FLAG] = write_collision_flag_reg;
      PRDATA[`IA_BIT_BUSY] = busy;
      PRDATA[`IA_BIT_SCLIN] = SCL_IN;
      PRDATA[`IA_BIT_SDAIN] = SDA_IN;
    end else if (is_addr(PADDR, `IA_OFF_BAUD)) begin
      PRDATA[BAUD_W-1:0] = baud_reg;
    end
  end
endmodule // i2cack_top
`default_nettype wire

//--- sim/iams_props.sv
// Port assertions for the acknowledge sequencer
`timescale 1ns/10ps
`default_nettype none
module iams_props (
  input wire REF_CLK,
  input wire RST_N,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  input wire PREADY,
  input wire PSLVERR,
  input wire SCL_IN,
  input wire SCL_OUT,
  input wire SCL_OE,
  input wire SDA_OUT,
  input wire SDA_OE
);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_N);
  wire acc = PSEL && PENABLE;
  property p_od;
    SCL_OUT == 1'b0 && SDA_OUT == 1'b0;
  endproperty
  a_od: assert property (p_od) else $error("pin driven high");
  // Only from a released SCL, so a held-low idle is not mistaken for a start
  property p_start;
    acc && PWRITE && PADDR == 12'h000 && PWDATA[4] && !SCL_OE |=> SCL_OE && SDA_OE == !$past(PWDATA[5]);
  endproperty
  a_start: assert property (p_start) else $error("start wrong");
  property p_low;
    $fell(SCL_OE) |-> $past(SCL_OE, 10);
  endproperty
  a_low: assert property (p_low) else $error("low phase short");
  property p_wait;
    !SCL_OE && !SCL_IN |=> !SCL_OE;
  endproperty
  a_wait: assert property (p_wait) else $error("stretch ignored");
  property p_high;
    $rose(SCL_IN) && !SCL_OE |-> !SCL_OE [*8] ##[1:4] SCL_OE;
  endproperty
  a_high: assert property (p_high) else $error("high phase wrong");
  property p_end;
    $fell(SDA_OE) |-> SCL_OE;
  endproperty
  a_end: assert property (p_end) else $error("SDA freed, SCL high");
  property p_sda;
    !SCL_OE |-> $stable(SDA_OE);
  endproperty
  a_sda: assert property (p_sda) else $error("SDA moved, SCL high");
  property p_err;
    acc && PADDR > 12'h00C |-> PSLVERR && PREADY;
  endproperty
  a_err: assert property (p_err) else $error("unmapped not refused");
  c_end: cover property ($fell(SDA_OE));
  c_str: cover property (!SCL_OE && !SCL_IN);
  c_err: cover property (acc && PSLVERR);
endmodule // iams_props
bind i2cack_top iams_props u_props (.REF_CLK(REF_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .SCL_IN(SCL_IN),
  .SCL_OUT(SCL_OUT), .SCL_OE(SCL_OE), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE));
`default_nettype wire

//--- sim/iams_slave.sv
// Far-side bus party: pull-ups and a slave that may stretch SCL
`timescale 1ns/10ps
`default_nettype none
module iams_slave (
  input wire logic scl_oe,
  input wire logic sda_oe,
  input wire logic stretch,
  output logic scl_in,
  output logic sda_in
);
  // Wired-AND with pull-ups: any party pulling low wins
  assign scl_in = !(scl_oe || stretch);
  assign sda_in = !sda_oe;
endmodule // iams_slave
`default_nettype wire

//--- sim/test_i2c_master_ack_sequencer.sv
// Register-level tests of the acknowledge sequencer
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module test_i2c_master_ack_sequencer;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, stretch = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, q;
  wire pready, pslverr, scl_in, sda_in, scl_oe, sda_oe;
  int n_fail = 0, check_count = 0;
  logic e;
  i2cack_top dut (.REF_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .SCL_IN(scl_in),
    .SCL_OUT(), .SCL_OE(scl_oe), .SDA_IN(sda_in), .SDA_OUT(), .SDA_OE(sda_oe));
  iams_slave u_slv (.scl_oe(scl_oe), .sda_oe(sda_oe), .stretch(stretch), .scl_in(scl_in), .sda_in(sda_in));
  initial begin
    forever #20 clk = ~clk;
  end
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
  endtask
  // Poll the busy flag at most 61 times; still busy after that counts as a failed check
  task wait_idle;
    apb(0, 12'h008, 0);
    for (int i = 0; i < 60 && q[1] !== 1'b0; i++) apb(0, 12'h008, 0);
    `CHK(q[1], 1'b0)
  endtask
  task summarize;
    $display("checks %0d fails %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    n_fail++;
    summarize;
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1;
    apb(0, 12'h00C, 0); `CHK(q[7:0], 8'h09)
    apb(1, 12'h004, 32'h5A);
    apb(1, 12'h000, 32'h10);
    @(negedge clk); `CHK({scl_oe, sda_oe}, 2'b11)
    apb(1, 12'h004, 32'hA5);
    apb(0, 12'h008, 0); `CHK(q[1:0], 2'h3)
    apb(0, 12'h004, 0); `CHK(q[7:0], 8'h5A)
    apb(0, 12'h000, 0); `CHK(q[4], 1'b1)
    wait_idle;
    apb(0, 12'h000, 0); `CHK(q[4], 1'b0)
    `CHK({scl_oe, sda_oe}, 2'b10)
    apb(1, 12'h008, 32'h1);
    apb(0, 12'h008, 0); `CHK(q[0], 1'b0)
    stretch <= 1;
    apb(1, 12'h000, 32'h30);
    @(negedge clk); `CHK({scl_oe, sda_oe}, 2'b10)
    fork
      begin
        @(negedge scl_oe);
        repeat (6) @(posedge clk);
        stretch <= 0;
      end
    join_none
    wait_idle;
    apb(0, 12'h000, 0); `CHK(q[4], 1'b0)
    apb(0, 12'h010, 0); `CHK(e, 1'b1)
    summarize;
  end
endmodule // test_i2c_master_ack_sequencer
`default_nettype wire
